// ==== hw/srl_defs.vh ====
// Purpose: constants of the serial rom configuration loader
// Assumes: included by every srl design file
// Notes: definitions only
`ifndef SRL_DEFS_VH
`define SRL_DEFS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SRL_NPORT 4
`define SRL_NREG 6
`define SRL_ROM_AW 8
`define SRL_BUS_AW 11

// ----------------------------------------------------------------
// rom word addresses, fetched in ascending order
// ----------------------------------------------------------------
`define SRL_WORD_A 8'h06
`define SRL_WORD_B 8'h0c

// ----------------------------------------------------------------
// per-port configuration offsets (byte offset within a port)
// ----------------------------------------------------------------
`define SRL_OFF_VCCNT 9'h144
`define SRL_OFF_LINKCAP 9'h0cc
`define SRL_OFF_SWMODE 9'h074
`define SRL_OFF_INTPIN 9'h03c
`define SRL_OFF_DEVCAP 9'h0c4
`define SRL_OFF_CAPDIS 9'h070
// loader control and status, port field zero only
`define SRL_OFF_CTRL 9'h1f0
`define SRL_OFF_STAT 9'h1f4
`define SRL_OFF_RAW_A 9'h1f8
`define SRL_OFF_RAW_B 9'h1fc

// ----------------------------------------------------------------
// bank register indices
// ----------------------------------------------------------------
`define SRL_IDX_VCCNT 3'h0
`define SRL_IDX_LINKCAP 3'h1
`define SRL_IDX_SWMODE 3'h2
`define SRL_IDX_INTPIN 3'h3
`define SRL_IDX_DEVCAP 3'h4
`define SRL_IDX_CAPDIS 3'h5
`define SRL_IDX_NONE 3'h7

// ----------------------------------------------------------------
// port sets that receive the loaded bits
// ----------------------------------------------------------------
`define SRL_PORTS_ALL 4'h7
`define SRL_PORTS_INT 4'h6

// ----------------------------------------------------------------
// field positions and masks of the target registers
// ----------------------------------------------------------------
`define SRL_VC_LSB 0
`define SRL_VC_MASK 32'h00000001
`define SRL_L0S_LSB 12
`define SRL_L1_LSB 15
`define SRL_ASPM_LSB 10
`define SRL_LC_A_MASK 32'h0003f000
`define SRL_LC_B_MASK 32'h00000c00
`define SRL_SW_SAF_BIT 0
`define SRL_SW_CT_LSB 1
`define SRL_SW_ARB_BIT 3
`define SRL_SW_CRD_BIT 4
`define SRL_SW_NOEG_BIT 5
`define SRL_SW_NOTAG_BIT 6
`define SRL_SW_CPPD_BIT 15
`define SRL_SW_A_MASK 32'h0000007f
`define SRL_SW_B_MASK 32'h00008000
`define SRL_IP_BIT 8
`define SRL_IP_MASK 32'h00000100
`define SRL_MPS_LSB 0
`define SRL_RBER_BIT 15
`define SRL_DC_MASK 32'h00008003
`define SRL_PMD_BIT 13
`define SRL_MSID_BIT 14
`define SRL_CD_MASK 32'h00006000

// ----------------------------------------------------------------
// control and status bits, reset values
// ----------------------------------------------------------------
`define SRL_CTRL_RELOAD_BIT 0
`define SRL_STAT_DONE_BIT 0
`define SRL_STAT_BUSY_BIT 1
`define SRL_RST_VAL 32'h00000000

`endif

// ==== hw/srl_rom_fetch.v ====
// Purpose: fetches one 16-bit word from the rom word port
// Assumes: rom word port runs on core_clk, answers each request once
// Notes: one request outstanding at a time
`timescale 1ns/100ps
`default_nettype none
`include "srl_defs.vh"

module srl_rom_fetch (
  input wire core_clk,
  input wire rst,
  input wire start,
  input wire [`SRL_ROM_AW-1:0] start_addr,
  output reg rom_req,
  output reg [`SRL_ROM_AW-1:0] rom_addr,
  input wire rom_ack,
  input wire [15:0] rom_data,
  output reg word_valid,
  output reg [15:0] word_data
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b01; // no request outstanding
  localparam ST_WAIT = 2'b10; // waiting for the rom answer

  reg [1:0] state_reg;

  // issue request, capture answer
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      rom_req <= 1'b0;
      rom_addr <= {`SRL_ROM_AW{1'b0}};
      word_valid <= 1'b0;
      word_data <= 16'h0000;
    end else begin
      rom_req <= 1'b0;
      word_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            rom_req <= 1'b1;
            rom_addr <= start_addr;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // an answer is only honoured after the request pulse
          if (rom_ack && !rom_req) begin
            word_valid <= 1'b1;
            word_data <= rom_data;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== hw/srl_port_bank.v ====
// Purpose: per-port configuration registers fed by the loader
// Assumes: load and bus write never in the same cycle
// Notes: entry index is {port, register index}
`timescale 1ns/100ps
`default_nettype none
`include "srl_defs.vh"

module srl_port_bank #(
  parameter NPORT = `SRL_NPORT
) (
  input wire core_clk,
  input wire rst,
  input wire ld_en,
  input wire [`SRL_NREG*32-1:0] ld_mask,
  input wire [`SRL_NREG*32-1:0] ld_val,
  input wire [`SRL_NREG*NPORT-1:0] ld_ports,
  input wire wr_en,
  input wire [1:0] wr_port,
  input wire [2:0] wr_idx,
  input wire [31:0] wr_data,
  input wire [1:0] rd_port,
  input wire [2:0] rd_idx,
  output wire [31:0] rd_data
);

  // ----------------------------------------------------------------
  // entries
  // ----------------------------------------------------------------
  wire [31:0] ent [0:NPORT*8-1]; // read view of each entry

  genvar e;
  generate
    for (e = 0; e < NPORT*8; e = e + 1) begin : g_ent
      if ((e % 8) < `SRL_NREG) begin : g_real
        reg [31:0] val_reg; // stored register value
        // merge loaded bits under mask, or take a bus write
        always @(posedge core_clk) begin
          if (rst) begin
            val_reg <= `SRL_RST_VAL;
          end else if (ld_en && ld_ports[(e%8)*NPORT + e/8]) begin
            val_reg <= (val_reg & ~ld_mask[(e%8)*32 +: 32]) |
                       (ld_val[(e%8)*32 +: 32] & ld_mask[(e%8)*32 +: 32]);
          end else if (wr_en && wr_port == e/8 && wr_idx == e%8) begin
            val_reg <= wr_data;
          end
        end
        assign ent[e] = val_reg;
      end else begin : g_none
        assign ent[e] = 32'h00000000; // no register here
      end
    end
  endgenerate

  assign rd_data = ent[{rd_port, rd_idx}];

endmodule
`default_nettype wire

// ==== hw/srl_loader.v ====
// Purpose: loads rom words 06h and 0ch into per-port configuration bits
// Assumes: rom word port and register port both on core_clk
// Notes: configuration writes are dropped and reads other than status return zero until the load is complete
`timescale 1ns/100ps
`default_nettype none
`include "srl_defs.vh"

module srl_loader (
  input wire core_clk,
  input wire rst,
  output wire rom_req,
  output wire [`SRL_ROM_AW-1:0] rom_addr,
  input wire rom_ack,
  input wire [15:0] rom_data,
  input wire [`SRL_BUS_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire cfg_ready
);

  // ----------------------------------------------------------------
  // states of the load sequence
  // ----------------------------------------------------------------
  localparam ST_REQA = 5'b00001; // ask for word 06h
  localparam ST_WAITA = 5'b00010; // wait for word 06h
  localparam ST_REQB = 5'b00100; // ask for word 0ch
  localparam ST_WAITB = 5'b01000; // wait for word 0ch
  localparam ST_DONE = 5'b10000; // loaded, config open

  reg [4:0] state_reg; // current state
  reg [4:0] state_next; // next state
  reg [15:0] raw_a_reg; // last word 06h seen
  reg [15:0] raw_b_reg; // last word 0ch seen

  wire fetch_start; // one-cycle start to the fetcher
  wire [`SRL_ROM_AW-1:0] fetch_addr; // rom word to fetch
  wire word_valid; // fetched word present
  wire [15:0] word_data; // fetched word
  wire reload; // software asks for a fresh load
  wire ld_en; // apply a word to the bank

  // ----------------------------------------------------------------
  // rom word fetcher
  // ----------------------------------------------------------------
  assign fetch_start = (state_reg == ST_REQA) || (state_reg == ST_REQB);
  // word 06h first, then 0ch
  assign fetch_addr = (state_reg == ST_REQB) ? `SRL_WORD_B : `SRL_WORD_A;

  srl_rom_fetch u_fetch (
    .core_clk(core_clk),
    .rst(rst),
    .start(fetch_start),
    .start_addr(fetch_addr),
    .rom_req(rom_req),
    .rom_addr(rom_addr),
    .rom_ack(rom_ack),
    .rom_data(rom_data),
    .word_valid(word_valid),
    .word_data(word_data)
  );

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  // next state: both words loaded before config opens
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_REQA: begin
        state_next = ST_WAITA;
      end
      ST_WAITA: begin
        if (word_valid) begin
          state_next = ST_REQB;
        end
      end
      ST_REQB: begin
        state_next = ST_WAITB;
      end
      ST_WAITB: begin
        if (word_valid) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (reload) begin
          state_next = ST_REQA;
        end
      end
      default: begin
        state_next = ST_REQA;
      end
    endcase
  end

  // state and raw word capture; reset starts a load at once
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_REQA;
      raw_a_reg <= 16'h0000;
      raw_b_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (word_valid && state_reg == ST_WAITA) begin
        raw_a_reg <= word_data;
      end
      if (word_valid && state_reg == ST_WAITB) begin
        raw_b_reg <= word_data;
      end
    end
  end

  assign cfg_ready = (state_reg == ST_DONE);
  assign ld_en = word_valid && (state_reg == ST_WAITA || state_reg == ST_WAITB);

  // ----------------------------------------------------------------
  // bit scatter of the two rom words
  // ----------------------------------------------------------------
  reg [31:0] m_vc; // masks per target register
  reg [31:0] m_lc;
  reg [31:0] m_sw;
  reg [31:0] m_ip;
  reg [31:0] m_dc;
  reg [31:0] m_cd;
  reg [31:0] v_vc; // values per target register
  reg [31:0] v_lc;
  reg [31:0] v_sw;
  reg [31:0] v_ip;
  reg [31:0] v_dc;
  reg [31:0] v_cd;

  // masks and values for the word being loaded
  always @* begin
    m_vc = 32'h00000000;
    m_lc = 32'h00000000;
    m_sw = 32'h00000000;
    m_ip = 32'h00000000;
    m_dc = 32'h00000000;
    m_cd = 32'h00000000;
    v_vc = 32'h00000000;
    v_lc = 32'h00000000;
    v_sw = 32'h00000000;
    v_ip = 32'h00000000;
    v_dc = 32'h00000000;
    v_cd = 32'h00000000;
    if (state_reg == ST_WAITA) begin
      // word 06h
      m_vc = `SRL_VC_MASK;
      v_vc[`SRL_VC_LSB] = word_data[0];
      m_lc = `SRL_LC_A_MASK;
      v_lc[`SRL_L0S_LSB +: 3] = word_data[3:1];
      v_lc[`SRL_L1_LSB +: 3] = word_data[6:4];
      m_sw = `SRL_SW_A_MASK;
      v_sw[`SRL_SW_NOEG_BIT] = word_data[8];
      v_sw[`SRL_SW_NOTAG_BIT] = word_data[9];
      v_sw[`SRL_SW_SAF_BIT] = word_data[10];
      v_sw[`SRL_SW_CT_LSB +: 2] = word_data[12:11];
      v_sw[`SRL_SW_ARB_BIT] = word_data[13];
      v_sw[`SRL_SW_CRD_BIT] = word_data[14];
      m_ip = `SRL_IP_MASK;
      v_ip[`SRL_IP_BIT] = word_data[15];
    end else if (state_reg == ST_WAITB) begin
      // word 0ch
      m_dc = `SRL_DC_MASK;
      v_dc[`SRL_MPS_LSB +: 2] = word_data[1:0];
      m_lc = `SRL_LC_B_MASK;
      v_lc[`SRL_ASPM_LSB +: 2] = word_data[3:2];
      v_dc[`SRL_RBER_BIT] = word_data[4];
      m_cd = `SRL_CD_MASK;
      v_cd[`SRL_MSID_BIT] = word_data[5];
      m_sw = `SRL_SW_B_MASK;
      v_sw[`SRL_SW_CPPD_BIT] = word_data[6];
      v_cd[`SRL_PMD_BIT] = word_data[7];
    end
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire [1:0] bus_port; // port field of the address
  wire [8:0] bus_off; // byte offset within the port
  reg [2:0] bus_idx; // bank index, none if unmapped
  wire [31:0] bank_rdata; // bank read view
  wire bank_wr; // bus write into the bank
  wire ctrl_hit; // access hits the own registers

  assign bus_port = reg_addr[10:9];
  assign bus_off = reg_addr[8:0];
  assign ctrl_hit = (bus_port == 2'h0);

  // offset to bank index
  always @* begin
    case (bus_off)
      `SRL_OFF_VCCNT: bus_idx = `SRL_IDX_VCCNT;
      `SRL_OFF_LINKCAP: bus_idx = `SRL_IDX_LINKCAP;
      `SRL_OFF_SWMODE: bus_idx = `SRL_IDX_SWMODE;
      `SRL_OFF_INTPIN: bus_idx = `SRL_IDX_INTPIN;
      `SRL_OFF_DEVCAP: bus_idx = `SRL_IDX_DEVCAP;
      `SRL_OFF_CAPDIS: bus_idx = `SRL_IDX_CAPDIS;
      default: bus_idx = `SRL_IDX_NONE;
    endcase
  end

  // config writes are held off until the load is complete
  assign bank_wr = reg_wr && cfg_ready && (bus_idx != `SRL_IDX_NONE);
  // reload pulse, accepted only once loaded
  assign reload = reg_wr && cfg_ready && ctrl_hit && (bus_off == `SRL_OFF_CTRL) &&
                  reg_wdata[`SRL_CTRL_RELOAD_BIT];

  // ----------------------------------------------------------------
  // per-port register bank
  // ----------------------------------------------------------------
  srl_port_bank #(
    .NPORT(`SRL_NPORT)
  ) u_bank (
    .core_clk(core_clk),
    .rst(rst),
    .ld_en(ld_en),
    .ld_mask({m_cd, m_dc, m_ip, m_sw, m_lc, m_vc}),
    .ld_val({v_cd, v_dc, v_ip, v_sw, v_lc, v_vc}),
    // intpin goes to ports 1-2 only, the rest to ports 0-2
    .ld_ports({`SRL_PORTS_ALL, `SRL_PORTS_ALL, `SRL_PORTS_INT,
               `SRL_PORTS_ALL, `SRL_PORTS_ALL, `SRL_PORTS_ALL}),
    .wr_en(bank_wr),
    .wr_port(bus_port),
    .wr_idx(bus_idx),
    .wr_data(reg_wdata),
    .rd_port(bus_port),
    .rd_idx(bus_idx),
    .rd_data(bank_rdata)
  );

  // ----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (ctrl_hit && bus_off == `SRL_OFF_STAT) begin
        // status always readable
        reg_rdata <= {30'h0, !cfg_ready, cfg_ready};
      end else if (!cfg_ready) begin
        reg_rdata <= 32'h00000000; // held off while loading
      end else if (ctrl_hit && bus_off == `SRL_OFF_RAW_A) begin
        reg_rdata <= {16'h0000, raw_a_reg};
      end else if (ctrl_hit && bus_off == `SRL_OFF_RAW_B) begin
        reg_rdata <= {16'h0000, raw_b_reg};
      end else begin
        reg_rdata <= bank_rdata; // zero when unmapped
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ==== tb/srl_rom_model.sv ====
// Purpose: serial config rom stand-in answering one word request at a time
// Assumes: requests are one-cycle pulses on core_clk
// Notes: data lines toggle while no answer is driven
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// rom word model
// ----------------------------------------
module srl_rom_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rom_req,
  input wire logic [7:0] rom_addr,
  input wire logic [15:0] word_a,
  input wire logic [15:0] word_b,
  input wire logic [3:0] lag,
  output logic rom_ack,
  output logic [15:0] rom_data
);
  logic busy_reg; // one request outstanding
  logic [4:0] cnt_reg; // cycles left before the answer
  logic [7:0] addr_reg; // captured word address
  // answer after lag+2 cycles, inverse pattern otherwise
  always @(posedge core_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      rom_ack <= 1'b0;
      rom_data <= 16'h5a5a;
    end else begin
      rom_ack <= 1'b0;
      rom_data <= ~rom_data;
      if (rom_req && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= {1'b0, lag} + 5'h1;
        addr_reg <= rom_addr;
      end else if (busy_reg && cnt_reg == 5'h0) begin
        busy_reg <= 1'b0;
        rom_ack <= 1'b1;
        rom_data <= (addr_reg == 8'h06) ? word_a : ((addr_reg == 8'h0c) ? word_b : 16'h0);
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/srl_checker.sv ====
// Purpose: port-level checks of the config loader
// Assumes: single core_clk domain, rst synchronous active high
// Notes: attached by bind from tb_top
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// loader checker
// ----------------------------------------
module srl_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rom_req,
  input wire logic [7:0] rom_addr,
  input wire logic rom_ack,
  input wire logic [15:0] rom_data,
  input wire logic [10:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cfg_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_req_pulse; rom_req |=> !rom_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("rom request longer than a cycle");
  property p_req_addr; rom_req |-> (rom_addr == 8'h06 || rom_addr == 8'h0c); endproperty
  a_req_addr: assert property (p_req_addr) else $error("rom request to unexpected word");
  property p_next_word; rom_ack && !rom_req && rom_addr == 8'h06 |-> ##[1:4] (rom_req && rom_addr == 8'h0c); endproperty
  a_next_word: assert property (p_next_word) else $error("second word not requested");
  property p_done; rom_ack && !rom_req && rom_addr == 8'h0c |-> ##[1:3] cfg_ready; endproperty
  a_done: assert property (p_done) else $error("load did not complete");
  property p_busy; rom_req |-> !cfg_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while fetching");
  property p_idle_rdata; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read answer");
  property p_blocked; reg_rd && !cfg_ready && reg_addr != 11'h1f4 |=> reg_rdata == 32'h0; endproperty
  a_blocked: assert property (p_blocked) else $error("read answered before load done");
  property p_stay; cfg_ready && !(reg_wr && reg_addr == 11'h1f0 && reg_wdata[0]) |=> cfg_ready; endproperty
  a_stay: assert property (p_stay) else $error("ready dropped without reload");
  c_load: cover property (rom_ack && rom_addr == 8'h0c);
  c_reload: cover property (cfg_ready && reg_wr && reg_addr == 11'h1f0);
  c_blocked: cover property (reg_rd && !cfg_ready);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the config loader
// Assumes: rom model answers with a random lag
// Notes: each round loads words then reads every mapped register
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rom_req, rom_ack, cfg_ready;
  logic [10:0] reg_addr = 11'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, got;
  logic [7:0] rom_addr;
  logic [15:0] rom_data, word_a = 16'hffff, word_b = 16'hffff;
  logic [3:0] lag = 4'h3;
  logic [8:0] offs [0:5]; // mapped offsets
  integer error_cnt = 0, checks = 0, seed = 32'h803d2501, p, r, k, n;
  always #25 core_clk = ~core_clk; // 20 MHz
  srl_loader dut_u (.core_clk(core_clk), .rst(rst), .rom_req(rom_req), .rom_addr(rom_addr),
    .rom_ack(rom_ack), .rom_data(rom_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_ready(cfg_ready));
  srl_rom_model rom_u (.core_clk(core_clk), .rst(rst), .rom_req(rom_req), .rom_addr(rom_addr),
    .word_a(word_a), .word_b(word_b), .lag(lag), .rom_ack(rom_ack), .rom_data(rom_data));
  // compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task print_verdict;
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task bus_wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task bus_rd(input logic [10:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_ready;
    for (k = 0; k < 300 && cfg_ready !== 1'b1; k = k + 1) @(posedge core_clk);
    if (cfg_ready !== 1'b1) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: load never completed", $time);
      print_verdict;
    end
  endtask
  // expected register value from the two rom words
  function logic [31:0] exp_val(input integer q, input logic [8:0] o, input logic [15:0] a,
    input logic [15:0] b);
    exp_val = 32'h0;
    if (q != 3) begin
      case (o)
        9'h144: exp_val[0] = a[0];
        9'h0cc: exp_val[17:10] = {a[6:4], a[3:1], b[3:2]};
        9'h074: exp_val[15:0] = {b[6], 8'h0, a[9], a[8], a[14], a[13], a[12:11], a[10]};
        9'h03c: exp_val[8] = (q != 0) ? a[15] : 1'b0;
        9'h0c4: exp_val[15:0] = {b[4], 13'h0, b[1:0]};
        default: exp_val[14:13] = {b[5], b[7]};
      endcase
    end
  endfunction
  task check_all;
    for (p = 0; p < 4; p = p + 1) begin
      for (r = 0; r < 6; r = r + 1) begin
        bus_rd({p[1:0], offs[r]}, got);
        chk(got, exp_val(p, offs[r], word_a, word_b));
      end
    end
    bus_rd(11'h1f8, got);
    chk(got, {16'h0, word_a});
    bus_rd(11'h1fc, got);
    chk(got, {16'h0, word_b});
  endtask
  // main sequence: blocked access, load rounds, bus writes
  initial begin
    offs[0] = 9'h144; offs[1] = 9'h0cc; offs[2] = 9'h074;
    offs[3] = 9'h03c; offs[4] = 9'h0c4; offs[5] = 9'h070;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    bus_rd(11'h0cc, got);
    chk(got, 32'h0);
    bus_wr(11'h674, 32'hffffffff);
    bus_rd(11'h1f4, got);
    chk({31'h0, got[0]}, 32'h0);
    wait_ready;
    check_all;
    for (n = 1; n < 5; n = n + 1) begin
      @(posedge core_clk);
      word_a <= (n == 1) ? 16'h0 : $random(seed);
      word_b <= (n == 1) ? 16'h0 : $random(seed);
      lag <= $random(seed) & 4'h7;
      bus_wr(11'h1f0, 32'h1);
      repeat (2) @(posedge core_clk);
      chk({31'h0, cfg_ready}, 32'h0);
      wait_ready;
      check_all;
    end
    bus_wr(11'h674, 32'hffffffff);
    bus_rd(11'h674, got);
    chk(got, 32'hffffffff);
    bus_rd(11'h100, got);
    chk(got, 32'h0);
    print_verdict;
  end
endmodule
bind srl_loader srl_checker chk_u (.core_clk(core_clk), .rst(rst), .rom_req(rom_req),
  .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_data(rom_data), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cfg_ready(cfg_ready));
`default_nettype wire
